// ===== rtl/rsw_pkg.sv
/*
   rsw_pkg: constants, register map, status word layout and state codes of
   the receive status word and receiver control block.
   Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package rsw_pkg;

   // ------------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W         = 8;
   localparam logic [7:0]  OFS_STAT_PORT  = 8'h00;
   localparam logic [7:0]  OFS_MAC_CTRL   = 8'h04;
   localparam logic [7:0]  OFS_RX_STATE   = 8'h08;
   localparam logic [7:0]  OFS_FLUSH      = 8'h0c;

   // ------------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------------
   localparam int unsigned CTRL_RECEIVE_ENABLE_BIT_BIT  = 2;
   localparam int unsigned CTRL_PASS_BIT  = 16;
   localparam int unsigned STATE_FAULT    = 0;
   localparam int unsigned STATE_ON       = 1;
   localparam int unsigned STATE_LVL_LSB  = 8;
   localparam int unsigned FLUSH_BIT      = 0;
   localparam logic        RECEIVE_ENABLE_BIT_RST       = 1'b0;
   localparam logic        PASS_RST       = 1'b0;

   // ------------------------------------------------------------------
   // frame figures, in bytes; dribble counts in bits
   // ------------------------------------------------------------------
   localparam logic [13:0] LEN_MAX        = 14'h3fff;
   localparam logic [13:0] RUNT_BYTES     = 14'h0040;
   localparam logic [13:0] MAX_FRAME      = 14'h05ee;
   localparam logic [13:0] TYPE_MIN_BYTES = 14'h000e;
   localparam logic [13:0] HDR_CRC_BYTES  = 14'h0012;
   localparam logic [13:0] DA_LAST_BYTE   = 14'h0005;
   localparam logic [13:0] LT_HI_BYTE     = 14'h000c;
   localparam logic [13:0] LT_LO_BYTE     = 14'h000d;
   localparam logic [15:0] MAX_LEN_FIELD  = 16'h05dc;
   localparam logic [15:0] MIN_PAYLOAD    = 16'h002e;
   localparam logic [13:0] WDOG_LO        = 14'h0800;
   localparam logic [13:0] WDOG_HI        = 14'h0a00;
   localparam logic [7:0]  BCAST_BYTE     = 8'hff;
   localparam logic [2:0]  DRIB_MII       = 3'h4;
   localparam logic [2:0]  DRIB_10M       = 3'h3;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        resv31;
      logic        filt_fail;
      logic [13:0] len;
      logic        err_sum;
      logic        resv14;
      logic        bcast;
      logic        len_err;
      logic        runt;
      logic        mcast;
      logic [1:0]  resv9_8;
      logic        too_long;
      logic        late_col;
      logic        eth_type;
      logic        wdog;
      logic        mii_err;
      logic        dribble;
      logic        crc_err;
      logic        resv0;
   } rsw_stat_t;

   typedef struct packed {
      logic       crc_ok;
      logic       filt_fail;
      logic       speed_10;
      logic [2:0] drib_bits;
   } rsw_end_t;

   typedef enum logic [1:0] {
      ST_OFF   = 2'b00,
      ST_IDLE  = 2'b01,
      ST_FRAME = 2'b10
   } rsw_state_t;

endpackage : rsw_pkg

// ===== rtl/rsw_stat_fifo.sv
/*
   rsw_stat_fifo: receive status word FIFO with push/pop handshakes.
   Assumes one clock; clear empties it and wins over push and pop.
*/
`timescale 1ns/1ns
`default_nettype none
module rsw_stat_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_sys_rst,
   input  wire logic                       i_clear,
   input  wire logic                       i_push_valid,
   output logic                            o_push_ready,
   input  wire logic [WIDTH-1:0]           i_push_data,
   output logic                            o_pop_valid,
   input  wire logic                       i_pop_ready,
   output logic [WIDTH-1:0]                o_pop_data,
   output logic [$clog2(DEPTH):0]          o_level
);
   localparam int unsigned AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   wire              full  = (wr_ptr_r ^ rd_ptr_r) == {1'b1, {AW{1'b0}}};
   wire              empty = wr_ptr_r == rd_ptr_r;
   wire              push  = i_push_valid & ~full;
   wire              pop   = i_pop_ready & ~empty;

   assign o_push_ready = ~full;
   assign o_pop_valid  = ~empty;
   assign o_pop_data   = mem[rd_ptr_r[AW-1:0]];
   assign o_level      = wr_ptr_r - rd_ptr_r;

   always_ff @(posedge i_ref_clk) begin
      if (push)
         mem[wr_ptr_r[AW-1:0]] <= i_push_data;
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else if (i_clear) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
         rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
      end
   end

endmodule : rsw_stat_fifo
`default_nettype wire

// ===== rtl/rsw_rx_status.sv
/*
   rsw_rx_status: builds one receive status word per frame, queues it in
   the status FIFO (runts only with pass-bad set), runs receiver enable/halt and the receive fault flag,
   and serves the registers as an Avalon-MM slave with waitrequest.
   Assumes the receive front end presents bytes in order while i_rx_dv is
   high and gives one i_rx_end pulse after the last byte of each frame.
*/
// The address map and the Avalon-MM slave port are this design's own decisions.
// Overview of operation
// (R1) reserved status bits always read zero
// (R2) bit 30 flags address filter failure
// (R3) bits 29:16 carry frame byte count
// (R4) bit 15 ORs runt, long, collision, CRC
// (R5) bit 13 flags broadcast destination
// (R6) bit 12 flags length field mismatch
// (R7) bit 11 flags frames under 64 bytes
// (R8) runts delivered only when pass-bad set
// (R9) bit 10 flags multicast destination
// (R10) bit 7 flags over 1518, no truncation
// (R11) bit 6 flags collision after window
// (R12) bit 5 flags type above 1500
// (R13) bit 4 flags receive watchdog expiry
// (R14) bit 3 flags receive error seen
// (R15) bit 2 flags dribble bits per mode
// (R16) no dribble flag with late collision
// (R17) bit 1 flags CRC or receive error
// (R18) CRC flag unreliable for runt/late/watchdog
// (R19) software clears enable to halt, sets to restart
// (R20) one halted pulse once reception stops
// (R21) software may flush FIFOs while stopped
// (R22) underrun or overrun raises fault, reception continues
// (R23) status word pushed after frame data
// (R24) fault flag holds until software clears
`timescale 1ns/1ns
`default_nettype none
module rsw_rx_status #(
   parameter logic [13:0] WDOG_BYTES = rsw_pkg::WDOG_LO,
   parameter int unsigned STAT_DEPTH = 16
) (
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_sys_rst,
   // receive front end
   input  wire logic                       i_rx_dv,
   input  wire logic                       i_rx_byte_vld,
   input  wire logic [7:0]                 i_rx_byte,
   input  wire logic                       i_rx_er,
   input  wire logic                       i_rx_col,
   input  wire logic                       i_rx_end,
   input  wire rsw_pkg::rsw_end_t          i_end_info,
   input  wire logic                       i_data_underrun,
   // register bus
   input  wire logic [rsw_pkg::ADDR_W-1:0] i_avs_address,
   input  wire logic                       i_avs_read,
   input  wire logic                       i_avs_write,
   input  wire logic [31:0]                i_avs_writedata,
   input  wire logic [3:0]                 i_avs_byteenable,
   output logic [31:0]                     o_avs_readdata,
   output logic                            o_avs_waitrequest,
   // events
   output logic                            o_rx_halted,
   output logic                            o_rx_fault
);
   localparam int unsigned LW = $clog2(STAT_DEPTH) + 1;

   initial begin
      if (WDOG_BYTES < rsw_pkg::WDOG_LO || WDOG_BYTES > rsw_pkg::WDOG_HI)
         $error("WDOG_BYTES must lie from 2048 to 2560");
   end

   // ------------------------------------------------------------------
   // register bus decode
   // ------------------------------------------------------------------
   logic                 ack_r;
   logic [31:0]          rdata_r;
   wire                  req     = i_avs_read | i_avs_write;
   wire                  take    = req & ack_r;
   wire                  wr_take = take & i_avs_write;
   wire                  rd_take = take & i_avs_read;
   wire                  sel_port  = i_avs_address == rsw_pkg::OFS_STAT_PORT;
   wire                  sel_ctrl  = i_avs_address == rsw_pkg::OFS_MAC_CTRL;
   wire                  sel_state = i_avs_address == rsw_pkg::OFS_RX_STATE;
   wire                  sel_flush = i_avs_address == rsw_pkg::OFS_FLUSH;
   wire                  wr_ctrl0  = wr_take & sel_ctrl & i_avs_byteenable[0];
   wire                  wr_ctrl2  = wr_take & sel_ctrl & i_avs_byteenable[2];
   wire                  clr_fault = wr_take & sel_state & i_avs_byteenable[0]
                                     & i_avs_writedata[rsw_pkg::STATE_FAULT];
   wire                  flush     = wr_take & sel_flush & i_avs_byteenable[0]
                                     & i_avs_writedata[rsw_pkg::FLUSH_BIT]; // R21
   wire                  pop_req   = rd_take & sel_port;

   assign o_avs_waitrequest = req & ~ack_r;
   assign o_avs_readdata    = rdata_r;

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------
   logic                 rx_en_r;
   logic                 pass_bad_r;

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rx_en_r    <= rsw_pkg::RECEIVE_ENABLE_BIT_RST;
         pass_bad_r <= rsw_pkg::PASS_RST;
      end else begin
         if (wr_ctrl0)
            rx_en_r <= i_avs_writedata[rsw_pkg::CTRL_RECEIVE_ENABLE_BIT_BIT]; // R19
         if (wr_ctrl2)
            pass_bad_r <= i_avs_writedata[rsw_pkg::CTRL_PASS_BIT];
      end
   end

   // ------------------------------------------------------------------
   // receiver state
   // ------------------------------------------------------------------
   rsw_pkg::rsw_state_t  state_r;
   rsw_pkg::rsw_state_t  state_nxt;
   logic                 dv_r;
   logic                 halted_nxt;
   wire                  start     = i_rx_dv & ~dv_r;
   wire                  in_frame  = state_r == rsw_pkg::ST_FRAME;
   wire                  frame_end = in_frame & i_rx_end;
   wire                  byte_in   = in_frame & i_rx_byte_vld;

   always_comb begin
      state_nxt  = state_r;
      halted_nxt = 1'b0;
      unique case (state_r)
         rsw_pkg::ST_OFF: begin
            if (rx_en_r)
               state_nxt = rsw_pkg::ST_IDLE;
         end
         rsw_pkg::ST_IDLE: begin
            if (!rx_en_r) begin
               state_nxt  = rsw_pkg::ST_OFF;
               halted_nxt = 1'b1; // R20
            end else if (start) begin
               state_nxt = rsw_pkg::ST_FRAME;
            end
         end
         rsw_pkg::ST_FRAME: begin
            if (i_rx_end) begin
               state_nxt  = rx_en_r ? rsw_pkg::ST_IDLE : rsw_pkg::ST_OFF;
               halted_nxt = ~rx_en_r; // R20
            end
         end
         default: begin
            state_nxt = rsw_pkg::ST_OFF;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_r     <= rsw_pkg::ST_OFF;
         dv_r        <= 1'b0;
         o_rx_halted <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         dv_r        <= i_rx_dv;
         o_rx_halted <= halted_nxt;
      end
   end

   // ------------------------------------------------------------------
   // per-frame collection
   // ------------------------------------------------------------------
   logic [13:0]          cnt_r;
   logic [15:0]          lt_r;
   logic                 bcast_r;
   logic                 mcast_r;
   logic                 late_r;
   logic                 mii_err_r;
   wire                  cnt_sat  = cnt_r == rsw_pkg::LEN_MAX;
   wire                  is_da    = cnt_r <= rsw_pkg::DA_LAST_BYTE;
   wire                  col_late = in_frame & i_rx_col
                                    & (cnt_r >= rsw_pkg::RUNT_BYTES);

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_r     <= '0;
         lt_r      <= '0;
         bcast_r   <= 1'b0;
         mcast_r   <= 1'b0;
         late_r    <= 1'b0;
         mii_err_r <= 1'b0;
      end else if (state_r == rsw_pkg::ST_IDLE && start) begin
         cnt_r     <= '0;
         lt_r      <= '0;
         bcast_r   <= 1'b1;
         mcast_r   <= 1'b0;
         late_r    <= 1'b0;
         mii_err_r <= i_rx_er;
      end else begin
         if (byte_in && !cnt_sat)
            cnt_r <= cnt_r + 14'h0001; // R10
         if (byte_in && is_da)
            bcast_r <= bcast_r & (i_rx_byte == rsw_pkg::BCAST_BYTE);
         if (byte_in && cnt_r == '0)
            mcast_r <= i_rx_byte[0];
         if (byte_in && cnt_r == rsw_pkg::LT_HI_BYTE)
            lt_r[15:8] <= i_rx_byte;
         if (byte_in && cnt_r == rsw_pkg::LT_LO_BYTE)
            lt_r[7:0] <= i_rx_byte;
         if (col_late)
            late_r <= 1'b1; // R11
         if (in_frame && i_rx_er)
            mii_err_r <= 1'b1; // R14
      end
   end

   // ------------------------------------------------------------------
   // status word assembly
   // ------------------------------------------------------------------
   rsw_pkg::rsw_stat_t   stat;
   wire [13:0]           data_len = cnt_r - rsw_pkg::HDR_CRC_BYTES;
   wire                  has_type = cnt_r >= rsw_pkg::TYPE_MIN_BYTES;
   wire                  is_len   = lt_r <= rsw_pkg::MAX_LEN_FIELD;
   wire                  padded   = (cnt_r == rsw_pkg::RUNT_BYTES)
                                    & (lt_r < rsw_pkg::MIN_PAYLOAD);
   wire                  len_bad  = (cnt_r < rsw_pkg::HDR_CRC_BYTES)
                                    | ({2'h0, data_len} != lt_r);
   wire                  runt     = cnt_r < rsw_pkg::RUNT_BYTES;
   wire                  drib_ok  = i_end_info.speed_10
                                    ? (i_end_info.drib_bits >= rsw_pkg::DRIB_10M)
                                    : (i_end_info.drib_bits == rsw_pkg::DRIB_MII);

   always_comb begin
      stat           = '0; // R1
      stat.filt_fail = i_end_info.filt_fail; // R2
      stat.len       = cnt_r; // R3
      stat.bcast     = bcast_r; // R5
      stat.len_err   = has_type & is_len & len_bad & ~padded; // R6
      stat.runt      = runt; // R7
      stat.mcast     = mcast_r & ~bcast_r; // R9
      stat.too_long  = cnt_r > rsw_pkg::MAX_FRAME; // R10
      stat.late_col  = late_r | col_late; // R11
      stat.eth_type  = has_type & ~is_len; // R12
      stat.wdog      = cnt_r > WDOG_BYTES; // R13
      stat.mii_err   = mii_err_r | i_rx_er; // R14
      stat.dribble   = drib_ok & ~stat.late_col; // R15 R16
      // still reported as seen; runt, late or watchdog make it unreliable
      stat.crc_err   = ~i_end_info.crc_ok | stat.mii_err; // R17 R18
      stat.err_sum   = stat.runt | stat.too_long | stat.late_col
                       | stat.crc_err; // R4
   end

   // ------------------------------------------------------------------
   // status FIFO
   // ------------------------------------------------------------------
   logic                 push_ready;
   logic                 pop_valid;
   logic [31:0]          pop_data;
   logic [LW-1:0]        level;
   wire                  push = frame_end & (~runt | pass_bad_r); // R8 R23

   rsw_stat_fifo #(
      .WIDTH (32),
      .DEPTH (STAT_DEPTH)
   ) u_stat_fifo (
      .i_ref_clk    (i_ref_clk),
      .i_sys_rst    (i_sys_rst),
      .i_clear      (flush),
      .i_push_valid (push),
      .o_push_ready (push_ready),
      .i_push_data  (stat),
      .o_pop_valid  (pop_valid),
      .i_pop_ready  (pop_req),
      .o_pop_data   (pop_data),
      .o_level      (level)
   );

   // ------------------------------------------------------------------
   // receive fault flag
   // ------------------------------------------------------------------
   wire                  overrun  = push & ~push_ready;
   wire                  underrun = pop_req & ~pop_valid;
   wire                  fault_ev = overrun | underrun | i_data_underrun; // R22

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst)
         o_rx_fault <= 1'b0;
      else if (fault_ev)
         o_rx_fault <= 1'b1; // R22 R24
      else if (clr_fault)
         o_rx_fault <= 1'b0; // R24
   end

   // ------------------------------------------------------------------
   // read data and bus answer
   // ------------------------------------------------------------------
   logic [31:0]          ctrl_word;
   logic [31:0]          state_word;
   logic [31:0]          rd_mux;

   always_comb begin
      ctrl_word                           = '0;
      ctrl_word[rsw_pkg::CTRL_RECEIVE_ENABLE_BIT_BIT]   = rx_en_r;
      ctrl_word[rsw_pkg::CTRL_PASS_BIT]   = pass_bad_r;
      state_word                          = '0;
      state_word[rsw_pkg::STATE_FAULT]    = o_rx_fault;
      state_word[rsw_pkg::STATE_ON]       = state_r != rsw_pkg::ST_OFF;
      state_word[rsw_pkg::STATE_LVL_LSB +: LW] = level;
      if (sel_port)
         rd_mux = pop_valid ? pop_data : '0;
      else if (sel_ctrl)
         rd_mux = ctrl_word;
      else if (sel_state)
         rd_mux = state_word;
      else
         rd_mux = '0;
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_r   <= 1'b0;
         rdata_r <= '0;
      end else begin
         ack_r <= req & ~ack_r;
         if (i_avs_read && !ack_r)
            rdata_r <= rd_mux;
      end
   end

endmodule : rsw_rx_status
`default_nettype wire

// ===== verification/rsw_rx_status_monitor.sv
/* rsw_rx_status_monitor: port-level checks of the receive status block.
   Assumes it is bound to rsw_rx_status and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module rsw_rx_status_monitor #(
   parameter logic [13:0] WDOG_BYTES = rsw_pkg::WDOG_LO
) (
   input wire logic        i_ref_clk,
   input wire logic        i_sys_rst,
   input wire logic [7:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic        i_data_underrun,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic        o_rx_halted,
   input wire logic        o_rx_fault
);
   // ---------------------------------------------
   // taken reads of the status port, state clears
   // ---------------------------------------------
   rsw_pkg::rsw_stat_t w;
   wire logic st = i_avs_read && !o_avs_waitrequest && i_avs_address == rsw_pkg::OFS_STAT_PORT;
   wire logic clr = i_avs_write && !o_avs_waitrequest && i_avs_address == rsw_pkg::OFS_RX_STATE;
   assign w = o_avs_readdata;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   AST_RESV_ZERO:
   assert property (st |-> !w.resv31 && !w.resv14 && w.resv9_8 == 2'h0 && !w.resv0)
      else $error("reserved status bit set");
   AST_ERR_SUM:
   assert property (st |-> w.err_sum == (w.runt | w.too_long | w.late_col | w.crc_err))
      else $error("summary bit wrong");
   AST_RUNT_LEN:
   assert property (st && w.runt |-> w.len < rsw_pkg::RUNT_BYTES) else $error("runt too long");
   AST_LONG_LEN:
   assert property (st |-> w.too_long == (w.len > rsw_pkg::MAX_FRAME)) else $error("long flag");
   AST_WDOG_LEN:
   assert property (st |-> w.wdog == (w.len > WDOG_BYTES)) else $error("watchdog flag");
   AST_TYPE_LEN:
   assert property (st && w.eth_type |-> w.len >= rsw_pkg::TYPE_MIN_BYTES)
      else $error("type flag on short frame");
   AST_DRIB_LATE:
   assert property (st && w.late_col |-> !w.dribble) else $error("dribble with collision");
   AST_CRC_MII:
   assert property (st && w.mii_err |-> w.crc_err) else $error("crc flag missing");
   AST_ONE_WAIT:
   assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("more than one wait state");
   AST_HALT_PULSE:
   assert property (o_rx_halted |=> !o_rx_halted) else $error("halt pulse too long");
   AST_FAULT_SET:
   assert property (i_data_underrun |=> o_rx_fault) else $error("fault not raised");
   AST_FAULT_HOLD:
   assert property (o_rx_fault && !clr |=> o_rx_fault) else $error("fault dropped");
   cover property (st && w.runt);
   cover property (st && w.wdog);
   cover property (o_rx_halted);
endmodule : rsw_rx_status_monitor
`default_nettype wire

// ===== verification/rsw_fe_model.sv
/* rsw_fe_model: receive front end that plays frames into the block.
   Assumes send is called from the bench right after a clock edge. */
`timescale 1ns/1ns
`default_nettype none
module rsw_fe_model (
   input  wire logic        i_ref_clk,
   output logic             o_rx_dv,
   output logic             o_rx_byte_vld,
   output logic [7:0]       o_rx_byte,
   output logic             o_rx_er,
   output logic             o_rx_col,
   output logic             o_rx_end,
   output rsw_pkg::rsw_end_t o_end_info
);
   initial begin
      {o_rx_dv, o_rx_byte_vld, o_rx_er, o_rx_col, o_rx_end} = 5'h00;
      o_rx_byte = 8'h5a;
      o_end_info = '0;
   end
   task send(input int n, input logic [7:0] b0, input logic [15:0] lt, input logic e,
             input logic c, input rsw_pkg::rsw_end_t f);
      @(posedge i_ref_clk);
      o_rx_dv <= 1'b1;
      o_rx_er <= e;
      for (int k = 0; k < n; k++) begin
         @(posedge i_ref_clk);
         o_rx_byte_vld <= 1'b1;
         o_rx_byte <= (k < 6) ? ((k == 0 || b0 == 8'hff) ? b0 : 8'h11) :
                      (k == 12) ? lt[15:8] : (k == 13) ? lt[7:0] : k[7:0];
      end
      @(posedge i_ref_clk);
      o_rx_byte_vld <= 1'b0;
      o_rx_byte <= ~o_rx_byte;
      o_rx_end <= 1'b1;
      o_rx_col <= c;
      o_end_info <= f;
      @(posedge i_ref_clk);
      {o_rx_dv, o_rx_end, o_rx_col, o_rx_er} <= 4'h0;
      o_end_info <= ~f;
   endtask : send
endmodule : rsw_fe_model
`default_nettype wire

// ===== verification/rsw_rx_status_tb_top.sv
/* rsw_rx_status_tb_top: register-level tests of the receive status block.
   Assumes the front-end model and the bound monitor. */
`timescale 1ns/1ns
`default_nettype none
module rsw_rx_status_tb_top;
   logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, und = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat;
   logic        wreq, halted, fault, dv, vld, er, col, fend;
   logic [7:0]  byt;
   rsw_pkg::rsw_end_t info;
   rsw_pkg::rsw_stat_t exp_q[$];
   int err_count = 0;
   int checks = 0;
   rsw_fe_model FE (.i_ref_clk(clk), .o_rx_dv(dv), .o_rx_byte_vld(vld), .o_rx_byte(byt),
      .o_rx_er(er), .o_rx_col(col), .o_rx_end(fend), .o_end_info(info));
   rsw_rx_status DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_rx_dv(dv), .i_rx_byte_vld(vld),
      .i_rx_byte(byt), .i_rx_er(er), .i_rx_col(col), .i_rx_end(fend), .i_end_info(info),
      .i_data_underrun(und), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdat), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .o_rx_halted(halted), .o_rx_fault(fault));
   initial begin
      forever #5 clk = ~clk;
   end
   // ---------------------------------------------
   // bus, compare and frame tasks
   // ---------------------------------------------
   task avs(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] d);
      @(posedge clk);
      {rd, wr} <= {!w, w};
      adr <= a;
      wdat <= v;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      d = rdat;
      {rd, wr} <= 2'b00;
   endtask : avs
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task frm(input int n, input logic [7:0] b0, input logic [15:0] lt, input logic e,
            input logic c, input rsw_pkg::rsw_end_t f, input bit q);
      rsw_pkg::rsw_stat_t s;
      s = '0;
      s.filt_fail = f.filt_fail;
      s.len = n[13:0];
      s.bcast = b0 == 8'hff;
      s.mcast = b0[0] && !s.bcast;
      s.runt = n < 64;
      s.too_long = n > 1518;
      s.late_col = c && n >= 64;
      s.eth_type = n >= 14 && lt > rsw_pkg::MAX_LEN_FIELD;
      s.wdog = n > 2048;
      s.mii_err = e;
      s.dribble = (f.speed_10 ? f.drib_bits >= 3'h3 : f.drib_bits == 3'h4) && !s.late_col;
      s.crc_err = !f.crc_ok || e;
      s.len_err = n >= 14 && lt <= rsw_pkg::MAX_LEN_FIELD && (n < 18 || n - 18 != lt)
                  && !(n == 64 && lt < 46);
      s.err_sum = s.runt | s.too_long | s.late_col | s.crc_err;
      if (q) exp_q.push_back(s);
      FE.send(n, b0, lt, e, c, f);
   endtask : frm
   task drain;
      logic [31:0] d;
      while (exp_q.size() > 0) begin
         avs(1'b0, rsw_pkg::OFS_STAT_PORT, 32'h0, d);
         chk("status word", exp_q.pop_front(), d);
      end
   endtask : drain
   task end_of_test;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      #300000;
      err_count++;
      end_of_test();
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      logic [31:0] d;
      int n;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      avs(1'b0, rsw_pkg::OFS_MAC_CTRL, 32'h0, d);
      chk("ctrl reset", 32'h0, d);
      avs(1'b1, 8'h10, 32'hffff_ffff, d);
      avs(1'b0, 8'h10, 32'h0, d);
      chk("unmapped", 32'h0, d);
      frm(64, 8'hff, 16'h002e, 1'b0, 1'b0, 6'h30, 1'b0);
      avs(1'b1, rsw_pkg::OFS_MAC_CTRL, 32'h4, d);
      avs(1'b0, rsw_pkg::OFS_RX_STATE, 32'h0, d);
      chk("state on", 32'h2, d);
      $display("test regs done");
      frm(64, 8'hff, 16'h002e, 1'b0, 1'b0, 6'h30, 1'b1);
      frm(63, 8'h22, 16'h002d, 1'b0, 1'b0, 6'h20, 1'b0);
      frm(1519, 8'h22, 16'h0800, 1'b0, 1'b1, 6'h04, 1'b1);
      frm(2049, 8'h22, 16'h05dc, 1'b0, 1'b0, 6'h3b, 1'b1);
      avs(1'b0, rsw_pkg::OFS_RX_STATE, 32'h0, d);
      chk("level", 32'h302, d);
      drain();
      $display("test frames done");
      avs(1'b1, rsw_pkg::OFS_MAC_CTRL, 32'h1_0004, d);
      frm(20, 8'h01, 16'h0005, 1'b1, 1'b0, 6'h24, 1'b1);
      drain();
      $display("test pass bad done");
      avs(1'b0, rsw_pkg::OFS_STAT_PORT, 32'h0, d);
      chk("empty read", 32'h0, d);
      repeat (5) @(posedge clk);
      chk("fault held", 32'h1, {31'h0, fault});
      avs(1'b1, rsw_pkg::OFS_RX_STATE, 32'h1, d);
      @(posedge clk);
      chk("fault clear", 32'h0, {31'h0, fault});
      und <= 1'b1;
      @(posedge clk);
      und <= 1'b0;
      @(posedge clk);
      chk("data underrun", 32'h1, {31'h0, fault});
      avs(1'b1, rsw_pkg::OFS_RX_STATE, 32'h1, d);
      $display("test fault done");
      frm(64, 8'h22, 16'h002e, 1'b0, 1'b0, 6'h20, 1'b0);
      avs(1'b1, rsw_pkg::OFS_MAC_CTRL, 32'h0, d);
      n = 0;
      repeat (6) begin
         @(posedge clk);
         if (halted === 1'b1) n++;
      end
      chk("halt pulses", 32'h1, n);
      frm(64, 8'h22, 16'h002e, 1'b0, 1'b0, 6'h20, 1'b0);
      avs(1'b0, rsw_pkg::OFS_RX_STATE, 32'h0, d);
      chk("halted level", 32'h100, d);
      avs(1'b1, rsw_pkg::OFS_FLUSH, 32'h1, d);
      avs(1'b0, rsw_pkg::OFS_RX_STATE, 32'h0, d);
      chk("flushed", 32'h0, d);
      $display("test halt done");
      end_of_test();
   end
endmodule : rsw_rx_status_tb_top
bind rsw_rx_status rsw_rx_status_monitor #(.WDOG_BYTES(WDOG_BYTES)) u_mon (
   .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_data_underrun(i_data_underrun),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .o_rx_halted(o_rx_halted), .o_rx_fault(o_rx_fault));
`default_nettype wire
